/* rtl/osc_trim_defines.vh */
/*
 * Register offsets, field positions, reset values and constants of the
 * oscillator trim calibration block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef OSC_TRIM_DEFINES_VH
`define OSC_TRIM_DEFINES_VH

`define ADDR_PRECISE_CAL_COUNTER 32'hffff0448
`define ADDR_LOWPOWER_CAL_COUNTER 32'hffff044c
`define ADDR_CAL_COUNTER_CONTROL 32'hffff0440
`define ADDR_LIN_CAL_CONTROL 32'hffff0480
`define ADDR_LOWPOWER_USER_TRIM 32'hffff0484
`define ADDR_PRECISE_USER_TRIM 32'hffff0488
`define ADDR_BAUD_UPPER_LIMIT 32'hffff048c
`define ADDR_BAUD_LOWER_LIMIT 32'hffff0490
`define ADDR_LIN_CAL_STATUS 32'hffff0494
`define ADDR_LOWPOWER_LIVE_TRIM 32'hffff0498
`define ADDR_PRECISE_LIVE_TRIM 32'hffff049c
`define ADDR_CAL_UNLOCK_KEY 32'hffff04a0

`define UNLOCK_KEY_VALUE 16'h1324
`define CONTROL_RESET 8'h00
`define STATUS_RESET 8'h01
`define LIMIT_RESET 20'h00000
`define CTRL_ENABLE_BIT 0
`define CTRL_STEP_LSB 1
`define CTRL_STEP_MSB 2
`define CTRL_SELECT_BIT 3
`define STA_SELECT_BIT 0
`define STA_PRECISE_MOD_BIT 1
`define STA_LOWPOWER_MOD_BIT 2
`define CNT_CTRL_RUN_BIT 0
`define CNT_CTRL_CLEAR_BIT 1
`define PRECISE_CNT_STOP 9'h1ff
`define LOWPOWER_TRIM_MAX 8'hff
`define PRECISE_TRIM_MAX 10'h3ff
`define LOWPOWER_TRIM_DEFAULT 8'h80
`define PRECISE_TRIM_DEFAULT 10'h200
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* rtl/osc_trim_calibration.v */
/*
 * Oscillator trim calibration: two calibration counters fed by
 * synchronised oscillator clocks, a LIN baud-rate calibrator stepping
 * live trims, and an AXI4-Lite register slave with key protection.
 * Assumes the LIN peripheral presents a measured baud value with a
 * one-cycle pulse on aclk when a sync field has been measured.
 */
// Chosen here: the AXI4-Lite slave port.
// Summary of operation
// [R1] Read-only 9-bit precision-clocked calibration counter
// [R2] Read-only 10-bit low-power-clocked calibration counter
// [R3] Low-power counter reads 11 bits, 10 used
// [R4] Trim derived from LIN sync field measurement
// [R5] Out-of-limits baud value adjusts selected trim
// [R6] Adjustment moves trim by configured step count
// [R7] Step field 0..3 gives step 1..4
// [R8] Trim only while enable bit set
// [R9] Calibrator writes live trims, never user trims
// [R10] Software copies live trim before disabling
// [R11] Status flags calibrator trim change
// [R12] Bit0 low-power select; flags clear on read
// [R13] Write-only key 0x1324 unlocks protected writes
// [R14] Protected registers accept only unlocked writes
// [R15] Upper baud limit read/write, resets zero
// [R16] Lower baud limit read/write, resets zero
// [R17] Read-only low-power live trim register
// [R18] Read-only precision live trim register
// [R19] User trims initialised by firmware, key protected
// [R20] System supplies enough LIN frames
// [R21] Control resets zero, status resets 0x01
// [R22] Counters stop when precision counter hits 0x1FF
// [R23] Fast raises trim, slow lowers, saturating
// [R24] Unlock covers only the next protected write
`timescale 1ns/1ps
`include "osc_trim_defines.vh"

module osc_trim_calibration (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Oscillator clocks, sampled as plain inputs
	input wire precise_osc_clk,
	input wire lowpower_osc_clk,
	// LIN baud measurement
	input wire [19:0] measured_baud_value,
	input wire baud_measured,
	// Trims applied to the oscillators
	output reg [7:0] lowpower_trim_out,
	output reg [9:0] precise_trim_out
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RESP = 2'b10;

	reg [1:0] wr_state;
	reg [31:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg w_held;
	reg unlocked;
	reg [7:0] lin_cal_control;
	reg [7:0] lowpower_user_trim;
	reg [9:0] precise_user_trim;
	reg [19:0] baud_upper_limit;
	reg [19:0] baud_lower_limit;
	reg sta_lowpower_mod;
	reg sta_precise_mod;
	reg [7:0] lowpower_live_trim;
	reg [10:0] precise_live_trim;
	reg [1:0] cnt_control;
	reg [8:0] precise_cal_counter;
	reg [9:0] lowpower_cal_counter;
	reg [2:0] precise_sync;
	reg [2:0] lowpower_sync;
	reg user_trim_loaded;
	reg [3:0] w_strb;
	wire [7:0] lin_cal_status;
	wire wr_go;
	wire rd_go;
	wire is_protected;
	wire select_lowpower;
	wire [3:0] step;
	wire too_fast;
	wire too_slow;
	wire cal_event;
	wire cnt_running;
	wire precise_edge;
	wire lowpower_edge;
	wire [10:0] lowpower_stepped;
	wire [10:0] precise_stepped;
	reg [31:0] next_rdata;
	reg next_rresp;

	// Decoding used by the write channel only
	function protected_addr;
		input [31:0] a;
		begin
			protected_addr = (a == `ADDR_LIN_CAL_CONTROL) || (a == `ADDR_LOWPOWER_USER_TRIM) ||
				(a == `ADDR_PRECISE_USER_TRIM);
		end
	endfunction

	// Write channel: address and data are latched in either order
	assign s_axi_awready = (wr_state == ST_IDLE) && !aw_held;
	assign s_axi_wready = (wr_state == ST_IDLE) && !w_held;
	assign wr_go = (wr_state == ST_IDLE) && aw_held && w_held;
	assign is_protected = protected_addr(aw_addr);

	// The response comes two edges after both halves are taken: one to
	// hold them, one to act, which keeps the decode off the ready path
	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= ST_IDLE;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			case (wr_state)
			ST_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr <= {s_axi_awaddr[31:2], 2'b00};
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (wr_go) begin
					aw_held <= 1'b0;
					w_held <= 1'b0;
					s_axi_bvalid <= 1'b1;
					s_axi_bresp <= (is_protected || aw_addr == `ADDR_BAUD_UPPER_LIMIT ||
						aw_addr == `ADDR_BAUD_LOWER_LIMIT || aw_addr == `ADDR_CAL_UNLOCK_KEY ||
						aw_addr == `ADDR_CAL_COUNTER_CONTROL ||
						aw_addr == `ADDR_PRECISE_CAL_COUNTER || aw_addr == `ADDR_LOWPOWER_CAL_COUNTER ||
						aw_addr == `ADDR_LIN_CAL_STATUS || aw_addr == `ADDR_LOWPOWER_LIVE_TRIM ||
						aw_addr == `ADDR_PRECISE_LIVE_TRIM) ? `RESP_OKAY : `RESP_SLVERR;
					wr_state <= ST_RESP;
				end
			end
			ST_RESP: begin
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
					wr_state <= ST_IDLE;
				end
			end
			default: wr_state <= ST_IDLE;
			endcase
		end
	end

	// Key register, the protected control register, baud limits and counter control
	always @(posedge aclk) begin
		if (!aresetn) begin
			unlocked <= 1'b0;
			lin_cal_control <= `CONTROL_RESET; // [R21]
			baud_upper_limit <= `LIMIT_RESET; // [R15]
			baud_lower_limit <= `LIMIT_RESET; // [R16]
			cnt_control <= 2'b00;
		end else if (wr_go) begin
			if (aw_addr == `ADDR_CAL_UNLOCK_KEY) begin
				// Any other value, or a key written in part, disarms the lock
				unlocked <= s_axi_wstrb_full(w_strb) && (w_data[15:0] == `UNLOCK_KEY_VALUE); // [R13]
			end else if (is_protected) begin
				unlocked <= 1'b0; // [R24]
				if (unlocked && aw_addr == `ADDR_LIN_CAL_CONTROL) begin
					lin_cal_control <= {4'h0, w_data[3:0]}; // [R14]
				end
			end
			if (aw_addr == `ADDR_BAUD_UPPER_LIMIT) begin
				baud_upper_limit <= w_data[19:0]; // [R15]
			end
			if (aw_addr == `ADDR_BAUD_LOWER_LIMIT) begin
				baud_lower_limit <= w_data[19:0]; // [R16]
			end
			if (aw_addr == `ADDR_CAL_COUNTER_CONTROL) begin
				cnt_control <= w_data[1:0];
			end
		end
	end

	// The key occupies the two low byte lanes; both must be written
	function s_axi_wstrb_full;
		input [3:0] strb;
		begin
			s_axi_wstrb_full = strb[0] && strb[1];
		end
	endfunction

	// User trims reset to their defaults and hold them until firmware writes them
	always @(posedge aclk) begin
		if (!aresetn) begin
			user_trim_loaded <= 1'b0;
			lowpower_user_trim <= `LOWPOWER_TRIM_DEFAULT;
			precise_user_trim <= `PRECISE_TRIM_DEFAULT;
		end else if (wr_go && unlocked) begin
			// Sees the lock as it stood before this write drops it
			if (aw_addr == `ADDR_LOWPOWER_USER_TRIM) begin
				lowpower_user_trim <= w_data[7:0]; // [R19]
				user_trim_loaded <= 1'b1;
			end
			if (aw_addr == `ADDR_PRECISE_USER_TRIM) begin
				precise_user_trim <= w_data[9:0]; // [R19]
				user_trim_loaded <= 1'b1;
			end
		end
	end

	// LIN calibrator
	// Inverted so that a cleared control register selects the low-power
	// oscillator: status then reads 0x01 out of reset with calibration off
	assign select_lowpower = !lin_cal_control[`CTRL_SELECT_BIT]; // [R12] [R21]
	assign step = {2'b00, lin_cal_control[`CTRL_STEP_MSB:`CTRL_STEP_LSB]} + 4'h1; // [R7]
	// A reading exactly on a limit counts as in range
	assign too_fast = measured_baud_value > baud_upper_limit;
	assign too_slow = measured_baud_value < baud_lower_limit;
	assign cal_event = lin_cal_control[`CTRL_ENABLE_BIT] && baud_measured && (too_fast || too_slow); // [R4] [R5] [R8]

	function [10:0] step_trim;
		input [10:0] cur;
		input [10:0] lim;
		input up;
		input [3:0] s;
		begin
			if (up) begin
				step_trim = (lim - cur < {7'h00, s}) ? lim : cur + {7'h00, s}; // [R23]
			end else begin
				step_trim = (cur < {7'h00, s}) ? 11'h000 : cur - {7'h00, s}; // [R23]
			end
		end
	endfunction

	// Both candidates are formed every cycle; the select picks one
	assign lowpower_stepped = step_trim({3'h0, lowpower_live_trim}, {3'h0, `LOWPOWER_TRIM_MAX}, too_fast, step);
	assign precise_stepped = step_trim({1'b0, precise_live_trim[9:0]}, {1'b0, `PRECISE_TRIM_MAX}, too_fast, step);

	always @(posedge aclk) begin
		if (!aresetn) begin
			lowpower_live_trim <= `LOWPOWER_TRIM_DEFAULT;
			precise_live_trim <= {1'b0, `PRECISE_TRIM_DEFAULT};
			sta_lowpower_mod <= 1'b0;
			sta_precise_mod <= 1'b0;
		end else begin
			// Status clears on read, but a same-cycle calibration event wins
			if (rd_go && s_axi_araddr[31:2] == `ADDR_LIN_CAL_STATUS >> 2) begin
				sta_lowpower_mod <= 1'b0; // [R12]
				sta_precise_mod <= 1'b0; // [R12]
			end
			if (cal_event) begin
				if (select_lowpower) begin
					lowpower_live_trim <= lowpower_stepped[7:0]; // [R6] [R9]
					sta_lowpower_mod <= 1'b1; // [R11]
				end else begin
					precise_live_trim <= {1'b0, precise_stepped[9:0]}; // [R6] [R9]
					sta_precise_mod <= 1'b1; // [R11]
				end
			end else if (!lin_cal_control[`CTRL_ENABLE_BIT] && user_trim_loaded) begin
				// Outside calibration, once a user trim has been written, the oscillators follow the user trims
				lowpower_live_trim <= lowpower_user_trim;
				precise_live_trim <= {1'b0, precise_user_trim};
			end
		end
	end

	// Applied trims lag the live registers by one edge so that the
	// oscillators only ever see registered values
	always @(posedge aclk) begin
		if (!aresetn) begin
			lowpower_trim_out <= `LOWPOWER_TRIM_DEFAULT;
			precise_trim_out <= `PRECISE_TRIM_DEFAULT;
		end else begin
			lowpower_trim_out <= lowpower_live_trim;
			precise_trim_out <= precise_live_trim[9:0];
		end
	end

	assign lin_cal_status = {5'h00, sta_lowpower_mod, sta_precise_mod, select_lowpower}; // [R12] [R21]

	// Calibration counters: oscillator clocks pass two flip-flops first
	always @(posedge aclk) begin
		if (!aresetn) begin
			precise_sync <= 3'b000;
			lowpower_sync <= 3'b000;
		end else begin
			precise_sync <= {precise_sync[1:0], precise_osc_clk};
			lowpower_sync <= {lowpower_sync[1:0], lowpower_osc_clk};
		end
	end

	assign precise_edge = precise_sync[1] && !precise_sync[2];
	assign lowpower_edge = lowpower_sync[1] && !lowpower_sync[2];
	assign cnt_running = cnt_control[`CNT_CTRL_RUN_BIT] && (precise_cal_counter != `PRECISE_CNT_STOP); // [R22]

	always @(posedge aclk) begin
		// A clear held high keeps both counters at zero and overrides run
		if (!aresetn || cnt_control[`CNT_CTRL_CLEAR_BIT]) begin
			precise_cal_counter <= 9'h000;
			lowpower_cal_counter <= 10'h000;
		end else if (cnt_running) begin
			if (precise_edge) begin
				precise_cal_counter <= precise_cal_counter + 9'h001; // [R1]
			end
			if (lowpower_edge) begin
				lowpower_cal_counter <= lowpower_cal_counter + 10'h001; // [R2]
			end
		end
	end

	// Read channel: one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	always @* begin
		next_rresp = 1'b0;
		case ({s_axi_araddr[31:2], 2'b00})
		`ADDR_PRECISE_CAL_COUNTER: next_rdata = {23'h000000, precise_cal_counter}; // [R1]
		`ADDR_LOWPOWER_CAL_COUNTER: next_rdata = {21'h000000, 1'b0, lowpower_cal_counter}; // [R3]
		`ADDR_CAL_COUNTER_CONTROL: next_rdata = {30'h00000000, cnt_control};
		`ADDR_LIN_CAL_CONTROL: next_rdata = {24'h000000, lin_cal_control};
		`ADDR_LOWPOWER_USER_TRIM: next_rdata = {24'h000000, lowpower_user_trim};
		`ADDR_PRECISE_USER_TRIM: next_rdata = {22'h000000, precise_user_trim};
		`ADDR_BAUD_UPPER_LIMIT: next_rdata = {12'h000, baud_upper_limit};
		`ADDR_BAUD_LOWER_LIMIT: next_rdata = {12'h000, baud_lower_limit};
		`ADDR_LIN_CAL_STATUS: next_rdata = {24'h000000, lin_cal_status};
		`ADDR_LOWPOWER_LIVE_TRIM: next_rdata = {24'h000000, lowpower_live_trim}; // [R17]
		`ADDR_PRECISE_LIVE_TRIM: next_rdata = {21'h000000, precise_live_trim}; // [R18]
		`ADDR_CAL_UNLOCK_KEY: next_rdata = 32'h00000000; // [R13]
		default: begin
			next_rdata = 32'h00000000;
			next_rresp = 1'b1;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // osc_trim_calibration

/* test/trim_checker.sv */
/* Port checker of the oscillator trim block.
   Assumes a bind to every instance of the design. */
`timescale 1ns/1ps
module trim_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	// Calibration
	input wire logic baud_measured,
	input wire logic [7:0] lowpower_trim_out,
	input wire logic [9:0] precise_trim_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles since anything that may move a trim
	logic [3:0] quiet;
	always @(posedge aclk)
		if (!aresetn || s_axi_wvalid || baud_measured) quiet <= 4'h0;
		else if (quiet != 4'hf) quiet <= quiet + 4'h1;
	AST_TRIM_QUIET: assert property (quiet > 4'h4 |-> $stable(precise_trim_out) && $stable(lowpower_trim_out))
		else $error("trim moved without cause");
	AST_RESET_STATE: assert property ($rose(aresetn) |-> lowpower_trim_out == 8'h80 && precise_trim_out == 10'h200
		&& !s_axi_bvalid && !s_axi_rvalid) else $error("bad state after reset");
	AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_WRITE_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	AST_BVALID_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_ARREADY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (s_axi_rvalid |=> !s_axi_rvalid || $stable(s_axi_rdata))
		else $error("read data moved");
endmodule // trim_checker

bind osc_trim_calibration trim_checker chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
	.s_axi_rresp, .baud_measured, .lowpower_trim_out, .precise_trim_out);

/* test/lin_baud_source.sv */
/* LIN baud measurement and both oscillators, far side of the trim block.
   Assumes the bench calls send right after a rising edge of aclk. */
`timescale 1ns/1ps
module lin_baud_source (
	// Clock
	input wire logic aclk,
	// Measurement
	output logic [19:0] measured_baud_value,
	output logic baud_measured,
	// Oscillators
	output logic precise_osc_clk,
	output logic lowpower_osc_clk
);
	initial begin
		measured_baud_value = 20'h0;
		baud_measured = 1'b0;
		precise_osc_clk = 1'b0;
		lowpower_osc_clk = 1'b0;
	end
	// Rates differ so the two counters end apart
	always #100 precise_osc_clk = ~precise_osc_clk;
	always #115 lowpower_osc_clk = ~lowpower_osc_clk;
	// One measured sync field after an idle gap
	task send(input logic [19:0] v, input int gap);
		repeat (gap) @(posedge aclk);
		measured_baud_value <= v;
		baud_measured <= 1'b1;
		@(posedge aclk);
		baud_measured <= 1'b0;
		// Stale value must not be trusted
		measured_baud_value <= ~v;
	endtask
endmodule // lin_baud_source

/* test/testbench.sv */
/* Self-checking bench of the oscillator trim block.
   Assumes lin_baud_source drives the LIN side and the oscillators. */
`timescale 1ns/1ps
`include "osc_trim_defines.vh"
module testbench;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, baud_measured;
	logic precise_osc_clk, lowpower_osc_clk;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [19:0] measured_baud_value;
	logic [7:0] lowpower_trim_out;
	logic [9:0] precise_trim_out;
	logic [15:0] seed = 16'hbf82;
	int failures = 0, total_checks = 0;
	logic [1:0] last_bresp;
	osc_trim_calibration DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .precise_osc_clk,
		.lowpower_osc_clk, .measured_baud_value, .baud_measured, .lowpower_trim_out, .precise_trim_out);
	lin_baud_source lin (.aclk, .measured_baud_value, .baud_measured, .precise_osc_clk, .lowpower_osc_clk);
	initial forever #12.5 aclk = ~aclk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Saturating trim step
	function automatic logic [9:0] stepped(input logic [9:0] t, mx, input int s, input logic up);
		if (up) return (t + s > mx) ? mx : 10'(t + s);
		return (t < s) ? 10'h0 : 10'(t - s);
	endfunction
	task give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [31:0] a, d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		last_bresp = s_axi_bresp;
		if (n == 100) failures++;
	endtask
	task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (n == 100) failures++;
	endtask
	task rc(input logic [31:0] a, exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, exp);
	endtask
	task pw(input logic [31:0] a, d);
		wr(`ADDR_CAL_UNLOCK_KEY, 32'h1324);
		wr(a, d);
	endtask
	initial begin : main
		logic [31:0] v;
		logic [1:0] r;
		logic [19:0] lim;
		logic [9:0] ep;
		logic [7:0] el;
		logic sel, up;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`ADDR_LIN_CAL_CONTROL, 32'h0);
		rc(`ADDR_LIN_CAL_STATUS, 32'h1);
		rc(`ADDR_BAUD_UPPER_LIMIT, 32'h0);
		rc(`ADDR_BAUD_LOWER_LIMIT, 32'h0);
		rc(`ADDR_PRECISE_CAL_COUNTER, 32'h0);
		rc(`ADDR_LOWPOWER_CAL_COUNTER, 32'h0);
		rd(32'hffff04a4, v, r);
		chk({v[29:0], r}, {30'h0, `RESP_SLVERR});
		wr(`ADDR_PRECISE_LIVE_TRIM, 32'h3);
		chk({30'h0, last_bresp}, {30'h0, `RESP_OKAY});
		wr(32'hffff04a4, 32'h1);
		chk({30'h0, last_bresp}, {30'h0, `RESP_SLVERR});
		rc(`ADDR_PRECISE_LIVE_TRIM, 32'h200);
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			v = {12'h0, seed, seed[15:12]};
			wr(i ? `ADDR_BAUD_LOWER_LIMIT : `ADDR_BAUD_UPPER_LIMIT, v);
			rc(i ? `ADDR_BAUD_LOWER_LIMIT : `ADDR_BAUD_UPPER_LIMIT, v);
		end
		wr(`ADDR_LIN_CAL_CONTROL, 32'h1);
		rc(`ADDR_LIN_CAL_CONTROL, 32'h0);
		wr(`ADDR_CAL_UNLOCK_KEY, 32'h1325);
		wr(`ADDR_LIN_CAL_CONTROL, 32'h1);
		rc(`ADDR_LIN_CAL_CONTROL, 32'h0);
		// A key written through one byte lane must not unlock
		s_axi_wstrb <= 4'h1;
		wr(`ADDR_CAL_UNLOCK_KEY, 32'h1324);
		s_axi_wstrb <= 4'hf;
		wr(`ADDR_LIN_CAL_CONTROL, 32'h1);
		rc(`ADDR_LIN_CAL_CONTROL, 32'h0);
		pw(`ADDR_PRECISE_USER_TRIM, 32'h2);
		wr(`ADDR_PRECISE_USER_TRIM, 32'h155);
		rc(`ADDR_PRECISE_USER_TRIM, 32'h2);
		pw(`ADDR_LOWPOWER_USER_TRIM, 32'hfd);
		rc(`ADDR_PRECISE_LIVE_TRIM, 32'h2);
		rc(`ADDR_LOWPOWER_LIVE_TRIM, 32'hfd);
		lim = 20'h10ab;
		wr(`ADDR_BAUD_LOWER_LIMIT, {12'h0, lim - 20'h20});
		wr(`ADDR_BAUD_UPPER_LIMIT, {12'h0, lim + 20'h20});
		lin.send(lim + 20'h21, 2);
		rc(`ADDR_PRECISE_LIVE_TRIM, 32'h2);
		ep = 10'h2;
		el = 8'hfd;
		for (int k = 0; k < 8; k++) begin
			sel = k[2];
			pw(`ADDR_LIN_CAL_CONTROL, {28'h0, ~sel, 2'(k), 1'b1});
			for (int dn = 0; dn < 3; dn++) begin
				up = (dn == 0) ~^ sel;
				seed = lfsr(seed);
				// Measurements come promptly or after a long pause
				lin.send(dn == 2 ? lim + 20'h20 : up ? lim + 20'h21 : lim - 20'h21, seed[0] ? 1 : 20);
				if (dn < 2 && sel) el = 8'(stepped({2'h0, el}, 10'hff, k % 4 + 1, up));
				if (dn < 2 && !sel) ep = stepped(ep, 10'h3ff, k % 4 + 1, up);
				rc(`ADDR_PRECISE_LIVE_TRIM, {22'h0, ep});
				rc(`ADDR_LOWPOWER_LIVE_TRIM, {24'h0, el});
				if (dn > 0) rc(`ADDR_LIN_CAL_STATUS, dn == 1 ? (sel ? 32'h5 : 32'h2) : {31'h0, sel});
			end
		end
		chk({22'h0, precise_trim_out}, {22'h0, ep});
		chk({24'h0, lowpower_trim_out}, {24'h0, el});
		rc(`ADDR_PRECISE_USER_TRIM, 32'h2);
		rc(`ADDR_LOWPOWER_USER_TRIM, 32'hfd);
		rd(`ADDR_PRECISE_LIVE_TRIM, v, r);
		pw(`ADDR_PRECISE_USER_TRIM, v);
		rd(`ADDR_LOWPOWER_LIVE_TRIM, v, r);
		pw(`ADDR_LOWPOWER_USER_TRIM, v);
		pw(`ADDR_LIN_CAL_CONTROL, 32'h0);
		rc(`ADDR_PRECISE_LIVE_TRIM, {22'h0, ep});
		rc(`ADDR_LOWPOWER_LIVE_TRIM, {24'h0, el});
		wr(`ADDR_CAL_COUNTER_CONTROL, 32'h1);
		repeat (5000) @(posedge aclk);
		rc(`ADDR_PRECISE_CAL_COUNTER, 32'h1ff);
		rd(`ADDR_LOWPOWER_CAL_COUNTER, v, r);
		repeat (20) @(posedge aclk);
		rc(`ADDR_LOWPOWER_CAL_COUNTER, v);
		chk(v & 32'hfffffc00, 32'h0);
		wr(`ADDR_CAL_COUNTER_CONTROL, 32'h2);
		rc(`ADDR_PRECISE_CAL_COUNTER, 32'h0);
		rc(`ADDR_LOWPOWER_CAL_COUNTER, 32'h0);
		give_verdict();
	end
	initial begin
		#(25 * 30000);
		failures++;
		give_verdict();
	end
endmodule // testbench
